// ===== design/mdl_decoder.sv
/*
  Decoder and sequencer for one instruction group: multiply, divide,
  ascii adjust, sign extend, shift/rotate, AND, TEST and OR.
  Assumes instruction bytes arrive on a valid/ready byte port synchronous
  to ref_clk; the count register value is supplied by the register file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mdl_defines.svh"

// Functional notes
// - Group opcode with select 101 is signed multiply, 25-28/34-37/31-34 (32-34 on the eight-bit bus)/40-43.
// - Opcode 011010s1 multiplies by immediate, 22-25 reg, 29-32 memory.
// - Group opcode with select 110 is unsigned divide, 29/38/35/44 clocks.
// - Group opcode with select 111 is signed divide, 44-52/53-61/50-58/59-67.
// - Bytes d4 then 0a adjust after product in 19 clocks.
// - Bytes d5 then 0a adjust before quotient in 15 clocks.
// - Opcode 98 extends byte accumulator to word in 2 clocks.
// - Opcode 99 extends word accumulator to double in 4 clocks.
// - Opcode 1101000w shifts by one, 2 register / 15 memory.
// - Opcode 1101001w shifts by count register, 5+n / 17+n.
// - Opcode 1100000w shifts by immediate count byte, 5+n / 17+n.
// - Shift op select 000 picks the first shift operation.
// - AND decodes rm 3/10, immediate select 100 4/16, accumulator 3/4.
// - TEST rm form 1000010w updates flags only, 3/10 clocks.
// - Group opcode select 000 tests against immediate, 4/10 clocks.
// - Opcode 1010100w tests accumulator against immediate, 3/4 clocks.
// - OR decodes rm 3/10, immediate select 001 4/16, accumulator 3/4.
// - Eight-bit bus adds 4 clocks per word memory transfer of multiply, divide, AND, TEST and OR; none for shifts or immediate multiply.
module mdl_decoder (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Configuration and operands
  input  wire logic             bus8,
  input  wire logic [7:0]       count_register,
  input  wire logic [3:0]       var_cycles,
  // Instruction byte stream
  input  wire logic             in_valid,
  input  wire logic [7:0]       in_byte,
  output logic                  in_ready,
  // Execution status
  output logic                  busy,
  output logic                  done,
  output logic                  illegal,
  output mdl_pkg::mdl_uop_s     uop,
  output mdl_pkg::mdl_cyc_t     cycles
);
  import mdl_pkg::*;

  typedef enum logic [2:0] {ST_OPC, ST_MODRM, ST_IMM, ST_LOAD, ST_EXEC}
    mdl_state_e;

  mdl_state_e state;
  mdl_state_e next_state;
  mdl_uop_s   opc_uop;
  mdl_uop_s   sel_uop;
  logic       imm_narrow;
  logic [1:0] imm_left;
  logic [7:0] shift_n;
  mdl_cyc_t   cnt;
  mdl_cyc_t   run_len;
  logic       take;

  // Pick a figure within a data-dependent range
  function automatic mdl_cyc_t rng(input mdl_cyc_t lo, input mdl_cyc_t hi,
                                   input logic [3:0] v);
    mdl_cyc_t sp;
    sp = hi - lo;
    rng = lo + ((mdl_cyc_t'(v) > sp) ? sp : mdl_cyc_t'(v));
  endfunction : rng

  // Classify the opcode byte
  function automatic mdl_uop_s dec_opc(input logic [7:0] b);
    mdl_uop_s u;
    u = '0;
    u.word = b[0];
    if (b[7:1] == `MDL_OPC_GRP3) begin
      u.op = OP_GRP3; u.form = FM_RM;
    end else if (b[7:2] == `MDL_OPC_IMULI && b[0]) begin
      u.op = OP_IMULI; u.form = FM_RM; u.word = 1'b1; u.to_reg = 1'b1;
    end else if (b == `MDL_OPC_AAM) begin
      u.op = OP_AAM; u.word = 1'b0;
    end else if (b == `MDL_OPC_AAD) begin
      u.op = OP_AAD; u.word = 1'b0;
    end else if (b == `MDL_OPC_CBW) begin
      u.op = OP_CBW; u.word = 1'b0;
    end else if (b == `MDL_OPC_CWD) begin
      u.op = OP_CWD; u.word = 1'b1;
    end else if (b[7:1] == `MDL_OPC_SH1) begin
      u.op = OP_SHIFT1; u.form = FM_RM;
    end else if (b[7:1] == `MDL_OPC_SHCL) begin
      u.op = OP_SHIFTCL; u.form = FM_RM;
    end else if (b[7:1] == `MDL_OPC_SHIMM) begin
      u.op = OP_SHIFTIMM; u.form = FM_RM;
    end else if (b[7:2] == `MDL_OPC_ANDRM) begin
      u.op = OP_AND; u.form = FM_RM; u.to_reg = b[1];
    end else if (b[7:1] == `MDL_OPC_ANDACC) begin
      u.op = OP_AND; u.form = FM_ACC; u.to_reg = 1'b1;
    end else if (b[7:2] == `MDL_OPC_ORRM) begin
      u.op = OP_OR; u.form = FM_RM; u.to_reg = b[1];
    end else if (b[7:1] == `MDL_OPC_ORACC) begin
      u.op = OP_OR; u.form = FM_ACC; u.to_reg = 1'b1;
    end else if (b[7:1] == `MDL_OPC_IMMGRP) begin
      u.op = OP_GRP1; u.form = FM_IMM;
    end else if (b[7:1] == `MDL_OPC_TESTRM) begin
      u.op = OP_TEST; u.form = FM_RM;
    end else if (b[7:1] == `MDL_OPC_TESTACC) begin
      u.op = OP_TEST; u.form = FM_ACC;
    end
    dec_opc = u;
  endfunction : dec_opc

  // Resolve the operand byte: memory flag, select field, group operation
  function automatic mdl_uop_s dec_sel(input mdl_uop_s u,
                                       input logic [7:0] m);
    mdl_uop_s r;
    r = u;
    r.mem = (m[7:6] != `MDL_MOD_REG);
    r.shift_op_select = m[5:3];
    if (u.op == OP_GRP3) begin
      unique case (m[5:3])
        `MDL_SEL_TEST: begin r.op = OP_TEST; r.form = FM_IMM; end
        `MDL_SEL_SIGNED_MULTIPLY: r.op = OP_SIGNED_MULTIPLY;
        `MDL_SEL_DIV:  r.op = OP_DIV;
        `MDL_SEL_SIGNED_QUOTIENT_OP: r.op = OP_SIGNED_QUOTIENT_OP;
        default:       r.op = OP_NONE;
      endcase
    end else if (u.op == OP_GRP1) begin
      unique case (m[5:3])
        `MDL_SEL_AND: r.op = OP_AND;
        `MDL_SEL_OR:  r.op = OP_OR;
        default:      r.op = OP_NONE;
      endcase
    end
    dec_sel = r;
  endfunction : dec_sel

  // Immediate bytes that follow the operand byte, or the opcode byte in accumulator forms
  function automatic logic [1:0] imm_count(input mdl_uop_s u,
                                           input logic narrow);
    if (u.op == OP_IMULI)
      imm_count = narrow ? 2'h1 : 2'h2;
    else if (u.op == OP_SHIFTIMM)
      imm_count = 2'h1;
    else if (u.form == FM_IMM || u.form == FM_ACC)
      imm_count = u.word ? 2'h2 : 2'h1;
    else
      imm_count = 2'h0;
  endfunction : imm_count

  // Clock count for a fully decoded instruction
  function automatic mdl_cyc_t calc_cycles(input mdl_uop_s u,
                                           input logic [7:0] n,
                                           input logic [3:0] v,
                                           input logic b8);
    mdl_cyc_t c;
    logic [1:0] xfer;
    c = '0;
    xfer = 2'h0;
    unique case (u.op)
      OP_SIGNED_MULTIPLY: begin
        xfer = 2'h1;
        if (u.mem)
          c = u.word ? rng(`MDL_SIGNED_MULTIPLY_MW_LO, `MDL_SIGNED_MULTIPLY_MW_HI, v)
            : rng(b8 ? `MDL_SIGNED_MULTIPLY_MB8_LO : `MDL_SIGNED_MULTIPLY_MB_LO,
                  `MDL_SIGNED_MULTIPLY_MB_HI, v);
        else
          c = u.word ? rng(`MDL_SIGNED_MULTIPLY_RW_LO, `MDL_SIGNED_MULTIPLY_RW_HI, v)
            : rng(`MDL_SIGNED_MULTIPLY_RB_LO, `MDL_SIGNED_MULTIPLY_RB_HI, v);
      end
      OP_IMULI: c = u.mem ? rng(`MDL_IMULI_M_LO, `MDL_IMULI_M_HI, v)
                   : rng(`MDL_IMULI_R_LO, `MDL_IMULI_R_HI, v);
      OP_DIV: begin
        xfer = 2'h1;
        c = u.mem ? (u.word ? `MDL_DIV_MW : `MDL_DIV_MB)
          : (u.word ? `MDL_DIV_RW : `MDL_DIV_RB);
      end
      OP_SIGNED_QUOTIENT_OP: begin
        xfer = 2'h1;
        if (u.mem)
          c = u.word ? rng(`MDL_SIGNED_QUOTIENT_OP_MW_LO, `MDL_SIGNED_QUOTIENT_OP_MW_HI, v)
            : rng(`MDL_SIGNED_QUOTIENT_OP_MB_LO, `MDL_SIGNED_QUOTIENT_OP_MB_HI, v);
        else
          c = u.word ? rng(`MDL_SIGNED_QUOTIENT_OP_RW_LO, `MDL_SIGNED_QUOTIENT_OP_RW_HI, v)
            : rng(`MDL_SIGNED_QUOTIENT_OP_RB_LO, `MDL_SIGNED_QUOTIENT_OP_RB_HI, v);
      end
      OP_AAM:   c = `MDL_AAM_CYC;
      OP_AAD:   c = `MDL_AAD_CYC;
      OP_CBW:   c = `MDL_CBW_CYC;
      OP_CWD:   c = `MDL_CWD_CYC;
      OP_SHIFT1: c = u.mem ? `MDL_SH1_M : `MDL_SH1_R;
      OP_SHIFTCL, OP_SHIFTIMM:
        c = (u.mem ? `MDL_SHN_M : `MDL_SHN_R) + mdl_cyc_t'(n);
      OP_AND, OP_OR: begin
        if (u.form == FM_ACC)
          c = u.word ? `MDL_ACC_W : `MDL_ACC_B;
        else if (u.form == FM_IMM) begin
          c = u.mem ? `MDL_LOGI_M : `MDL_LOGI_R;
          xfer = 2'h2;
        end else begin
          c = u.mem ? `MDL_LOG_M : `MDL_LOG_R;
          xfer = u.to_reg ? 2'h1 : 2'h2;
        end
      end
      OP_TEST: begin
        xfer = 2'h1;
        if (u.form == FM_ACC)
          c = u.word ? `MDL_ACC_W : `MDL_ACC_B;
        else if (u.form == FM_IMM)
          c = u.mem ? `MDL_TESTI_M : `MDL_TESTI_R;
        else
          c = u.mem ? `MDL_LOG_M : `MDL_LOG_R;
      end
      default: c = '0;
    endcase
    if (b8 && u.word && u.mem && xfer != 2'h0)
      c = c + `MDL_BUS8_EXTRA;
    if (b8 && u.word && u.mem && xfer == 2'h2)
      c = c + `MDL_BUS8_EXTRA;
    calc_cycles = c;
  endfunction : calc_cycles

  assign take    = in_valid && in_ready;
  assign opc_uop = dec_opc(in_byte);
  assign sel_uop = dec_sel(uop, in_byte);

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OPC: if (take) begin
        if (opc_uop.op == OP_NONE)
          next_state = ST_OPC;
        else if (opc_uop.op == OP_CBW || opc_uop.op == OP_CWD)
          next_state = ST_LOAD;
        else if (opc_uop.form == FM_ACC)
          next_state = ST_IMM;
        else
          next_state = ST_MODRM;
      end
      ST_MODRM: if (take) begin
        if (uop.op == OP_AAM || uop.op == OP_AAD)
          next_state = (in_byte == `MDL_ADJ_BASE) ? ST_LOAD : ST_OPC;
        else if (sel_uop.op == OP_NONE)
          next_state = ST_OPC;
        else if (imm_count(sel_uop, imm_narrow) != 2'h0)
          next_state = ST_IMM;
        else
          next_state = ST_LOAD;
      end
      ST_IMM:  if (take && imm_left == 2'h1) next_state = ST_LOAD;
      ST_LOAD: next_state = ST_EXEC;
      ST_EXEC: if (cnt == '0) next_state = ST_OPC;
    endcase
  end

  // State and byte handshake
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state    <= ST_OPC;
      in_ready <= 1'b0;
    end else begin
      state    <= next_state;
      in_ready <= (next_state == ST_OPC) || (next_state == ST_MODRM)
               || (next_state == ST_IMM);
    end
  end

  // Decoded record, immediate tracking and shift count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      uop        <= '0;
      imm_narrow <= 1'b0;
      imm_left   <= 2'h0;
      shift_n    <= 8'h00;
    end else if (take) begin
      unique case (state)
        ST_OPC: begin
          uop        <= opc_uop;
          imm_narrow <= in_byte[1];
          imm_left   <= imm_count(opc_uop, in_byte[1]);
          shift_n    <= 8'h00;
        end
        ST_MODRM: if (uop.op != OP_AAM && uop.op != OP_AAD) begin
          uop      <= sel_uop;
          imm_left <= imm_count(sel_uop, imm_narrow);
          if (uop.op == OP_SHIFTCL)
            shift_n <= count_register;
        end
        ST_IMM: begin
          imm_left <= imm_left - 2'h1;
          if (uop.op == OP_SHIFTIMM)
            shift_n <= in_byte;
        end
        default: ;
      endcase
    end
  end

  // Execution timing
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cycles <= '0;
      cnt    <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else if (state == ST_LOAD) begin
      cycles <= calc_cycles(uop, shift_n, var_cycles, bus8);
      cnt    <= calc_cycles(uop, shift_n, var_cycles, bus8) - 10'h001;
      busy   <= 1'b1;
      done   <= 1'b0;
    end else if (state == ST_EXEC) begin
      cnt  <= cnt - 10'h001;
      busy <= (cnt != '0);
      done <= (cnt == 10'h001);
    end else begin
      done <= 1'b0;
    end
  end

  // Rejected byte sequences
  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      illegal <= 1'b0;
    else
      illegal <= take && ((state == ST_OPC && opc_uop.op == OP_NONE)
        || (state == ST_MODRM && ((uop.op == OP_AAM || uop.op == OP_AAD)
          ? (in_byte != `MDL_ADJ_BASE) : (sel_uop.op == OP_NONE))));
  end

  // Busy run length for checking
  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      run_len <= '0;
    else
      run_len <= busy ? run_len + 10'h001 : '0;
  end

  property p_run_len;
    @(posedge ref_clk) disable iff (!rst_b)
      done |-> busy && run_len == cycles - 10'h001 ##1 !busy;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("busy length differs from cycle count");

  property p_signed_multiply_rb;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_SIGNED_MULTIPLY && !uop.mem && !uop.word
        |-> cycles >= `MDL_SIGNED_MULTIPLY_RB_LO && cycles <= `MDL_SIGNED_MULTIPLY_RB_HI;
  endproperty
  a_signed_multiply_rb: assert property (p_signed_multiply_rb)
    else $error("signed multiply byte count out of range");

  property p_imuli_reg;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_IMULI && !uop.mem
        |-> cycles >= `MDL_IMULI_R_LO && cycles <= `MDL_IMULI_R_HI;
  endproperty
  a_imuli_reg: assert property (p_imuli_reg)
    else $error("immediate multiply count out of range");

  property p_div_rw;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_DIV && !uop.mem && uop.word
        |-> cycles == `MDL_DIV_RW;
  endproperty
  a_div_rw: assert property (p_div_rw)
    else $error("unsigned divide word count wrong");

  property p_signed_quotient_op_rb;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_SIGNED_QUOTIENT_OP && !uop.mem && !uop.word
        |-> cycles >= `MDL_SIGNED_QUOTIENT_OP_RB_LO && cycles <= `MDL_SIGNED_QUOTIENT_OP_RB_HI;
  endproperty
  a_signed_quotient_op_rb: assert property (p_signed_quotient_op_rb)
    else $error("signed divide byte count out of range");

  property p_aam;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_AAM |-> run_len == `MDL_AAM_CYC - 10'h001;
  endproperty
  a_aam: assert property (p_aam)
    else $error("adjust after product not 19 clocks");

  property p_aad;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_AAD |-> cycles == `MDL_AAD_CYC;
  endproperty
  a_aad: assert property (p_aad)
    else $error("adjust before quotient not 15 clocks");

  property p_cbw;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(busy) && uop.op == OP_CBW |-> !done ##1 done ##1 !busy;
  endproperty
  a_cbw: assert property (p_cbw)
    else $error("byte extend not 2 clocks");

  property p_cwd;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(busy) && uop.op == OP_CWD |-> busy[*4] ##1 !busy;
  endproperty
  a_cwd: assert property (p_cwd)
    else $error("word extend not 4 clocks");

  property p_shift_cl;
    @(posedge ref_clk) disable iff (!rst_b)
      done && uop.op == OP_SHIFTCL && !uop.mem
        |-> cycles == `MDL_SHN_R + mdl_cyc_t'(shift_n);
  endproperty
  a_shift_cl: assert property (p_shift_cl)
    else $error("shift by count register timing wrong");

  property p_bus8_word;
    @(posedge ref_clk) disable iff (!rst_b)
      done && bus8 && uop.op == OP_DIV && uop.mem && uop.word
        |-> cycles == `MDL_DIV_MW + `MDL_BUS8_EXTRA;
  endproperty
  a_bus8_word: assert property (p_bus8_word)
    else $error("eight-bit bus word penalty missing");

endmodule : mdl_decoder
`default_nettype wire

// ===== shared/mdl_defines.svh
/*
  Opcode patterns, operand-byte select codes and clock counts for the
  multiply, divide, adjust, extend, shift and logic instruction decoder.
  Assumes the includer works at the processor clock.
*/
`ifndef MDL_DEFINES_SVH
`define MDL_DEFINES_SVH

// Opcode patterns (upper bits or all of the opcode byte) and the adjust base byte
`define MDL_OPC_GRP3     7'b1111011
`define MDL_OPC_IMULI    6'b011010
`define MDL_OPC_AAM      8'hd4
`define MDL_OPC_AAD      8'hd5
`define MDL_ADJ_BASE     8'h0a
`define MDL_OPC_CBW      8'h98
`define MDL_OPC_CWD      8'h99
`define MDL_OPC_SH1      7'b1101000
`define MDL_OPC_SHCL     7'b1101001
`define MDL_OPC_SHIMM    7'b1100000
`define MDL_OPC_ANDRM    6'b001000
`define MDL_OPC_ANDACC   7'b0010010
`define MDL_OPC_ORRM     6'b000010
`define MDL_OPC_ORACC    7'b0000110
`define MDL_OPC_IMMGRP   7'b1000000
`define MDL_OPC_TESTRM   7'b1000010
`define MDL_OPC_TESTACC  7'b1010100

// Operand byte fields
`define MDL_MOD_REG      2'b11
`define MDL_SEL_TEST     3'b000
`define MDL_SEL_OR       3'b001
`define MDL_SEL_AND      3'b100
`define MDL_SEL_SIGNED_MULTIPLY     3'b101
`define MDL_SEL_DIV      3'b110
`define MDL_SEL_SIGNED_QUOTIENT_OP     3'b111

// Clock counts
`define MDL_SIGNED_MULTIPLY_RB_LO   10'h019
`define MDL_SIGNED_MULTIPLY_RB_HI   10'h01c
`define MDL_SIGNED_MULTIPLY_RW_LO   10'h022
`define MDL_SIGNED_MULTIPLY_RW_HI   10'h025
`define MDL_SIGNED_MULTIPLY_MB_LO   10'h01f
`define MDL_SIGNED_MULTIPLY_MB8_LO  10'h020
`define MDL_SIGNED_MULTIPLY_MB_HI   10'h022
`define MDL_SIGNED_MULTIPLY_MW_LO   10'h028
`define MDL_SIGNED_MULTIPLY_MW_HI   10'h02b
`define MDL_IMULI_R_LO   10'h016
`define MDL_IMULI_R_HI   10'h019
`define MDL_IMULI_M_LO   10'h01d
`define MDL_IMULI_M_HI   10'h020
`define MDL_DIV_RB       10'h01d
`define MDL_DIV_RW       10'h026
`define MDL_DIV_MB       10'h023
`define MDL_DIV_MW       10'h02c
`define MDL_SIGNED_QUOTIENT_OP_RB_LO   10'h02c
`define MDL_SIGNED_QUOTIENT_OP_RB_HI   10'h034
`define MDL_SIGNED_QUOTIENT_OP_RW_LO   10'h035
`define MDL_SIGNED_QUOTIENT_OP_RW_HI   10'h03d
`define MDL_SIGNED_QUOTIENT_OP_MB_LO   10'h032
`define MDL_SIGNED_QUOTIENT_OP_MB_HI   10'h03a
`define MDL_SIGNED_QUOTIENT_OP_MW_LO   10'h03b
`define MDL_SIGNED_QUOTIENT_OP_MW_HI   10'h043
`define MDL_AAM_CYC      10'h013
`define MDL_AAD_CYC      10'h00f
`define MDL_CBW_CYC      10'h002
`define MDL_CWD_CYC      10'h004
`define MDL_SH1_R        10'h002
`define MDL_SH1_M        10'h00f
`define MDL_SHN_R        10'h005
`define MDL_SHN_M        10'h011
`define MDL_LOG_R        10'h003
`define MDL_LOG_M        10'h00a
`define MDL_LOGI_R       10'h004
`define MDL_LOGI_M       10'h010
`define MDL_ACC_B        10'h003
`define MDL_ACC_W        10'h004
`define MDL_TESTI_R      10'h004
`define MDL_TESTI_M      10'h00a
`define MDL_BUS8_EXTRA   10'h004

`endif

// ===== shared/mdl_pkg.sv
/*
  Types for the instruction decoder: operation, form and decoded record.
  Assumes mdl_defines.svh supplies the numeric constants.
*/
package mdl_pkg;
  typedef logic [9:0] mdl_cyc_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_GRP3, OP_GRP1, OP_SIGNED_MULTIPLY, OP_IMULI, OP_DIV, OP_SIGNED_QUOTIENT_OP,
    OP_AAM, OP_AAD, OP_CBW, OP_CWD, OP_SHIFT1, OP_SHIFTCL,
    OP_SHIFTIMM, OP_AND, OP_OR, OP_TEST
  } mdl_op_e;

  typedef enum logic [1:0] {FM_NONE, FM_RM, FM_IMM, FM_ACC} mdl_form_e;

  typedef struct packed {
    mdl_op_e   op;
    mdl_form_e form;
    logic      word;
    logic      to_reg;
    logic      mem;
    logic [2:0] shift_op_select;
  } mdl_uop_s;
endpackage : mdl_pkg

// ===== bench/mdl_decoder_tb.sv
/*
  Self-checking bench for the instruction decoder and sequencer.
  Assumes the design package and defines are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module mdl_decoder_tb;
  import mdl_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              bus8 = 1'b0;
  logic [7:0]        count_register = 8'h00;
  logic [3:0]        var_cycles = 4'h0;
  logic              in_valid = 1'b0;
  logic [7:0]        in_byte = 8'h00;
  logic              in_ready;
  logic              busy;
  logic              done;
  logic              illegal;
  mdl_uop_s          uop;
  mdl_cyc_t          cycles;
  int                n_fail = 0;
  int                tests_run = 0;

  mdl_decoder dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus8(bus8),
    .count_register(count_register), .var_cycles(var_cycles),
    .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
    .busy(busy), .done(done), .illegal(illegal), .uop(uop),
    .cycles(cycles));

  always #12.5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic cmp_cyc(input mdl_cyc_t a, input mdl_cyc_t e);
    tests_run++;
    if (a !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp_cyc

  task automatic cmp_op(input mdl_op_e a, input mdl_op_e e);
    tests_run++;
    if (a !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp_op

  task automatic cmp_bit(input logic a, input logic e);
    tests_run++;
    if (a !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp_bit

  task automatic timeout();
    n_fail++;
    $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask : timeout

  // Called just after a rising edge; holds the byte until taken
  task automatic send(input logic [7:0] b);
    int k;
    in_valid <= 1'b1;
    in_byte <= b;
    for (k = 0; k < 50; k++) begin
      @(negedge ref_clk);
      if (in_ready === 1'b1) break;
    end
    if (k == 50) timeout();
    @(posedge ref_clk);
  endtask : send

  // Sends n bytes (lowest first), then times busy and done
  task automatic r(input logic [31:0] b, input int n, input logic b8,
    input logic [3:0] v, input mdl_cyc_t e, input mdl_op_e op);
    int k;
    int nb;
    bus8 <= b8;
    var_cycles <= v;
    @(posedge ref_clk);
    for (k = 0; k < n; k++) send(b[8*k +: 8]);
    in_valid <= 1'b0;
    nb = 0;
    for (k = 0; k < 400; k++) begin
      @(negedge ref_clk);
      if (busy !== 1'b1 && nb > 0) break;
      if (busy === 1'b1) begin
        nb++;
        cmp_bit(done, nb == int'(e));
      end
    end
    if (k == 400) timeout();
    cmp_cyc(mdl_cyc_t'(nb), e);
    cmp_cyc(cycles, e);
    cmp_op(uop.op, op);
  endtask : r

  task automatic bad(input logic [31:0] b, input int n);
    int k;
    logic seen;
    logic ran;
    seen = 1'b0;
    ran = 1'b0;
    @(posedge ref_clk);
    for (k = 0; k < n; k++) send(b[8*k +: 8]);
    in_valid <= 1'b0;
    repeat (6) begin
      @(negedge ref_clk);
      seen = seen | (illegal === 1'b1);
      ran = ran | (busy === 1'b1);
    end
    cmp_bit(seen, 1'b1);
    cmp_bit(ran, 1'b0);
  endtask : bad

  task automatic t_mul();
    r(32'he8f6, 2, 0, 2, 27, OP_SIGNED_MULTIPLY);
    r(32'he8f7, 2, 0, 0, 34, OP_SIGNED_MULTIPLY);
    r(32'h28f6, 2, 1, 0, 32, OP_SIGNED_MULTIPLY);
    r(32'h28f7, 2, 1, 15, 47, OP_SIGNED_MULTIPLY);
    r(32'h05c06b, 3, 0, 1, 23, OP_IMULI);
    r(32'h34120069, 4, 1, 3, 32, OP_IMULI);
    $display("test mul finished");
  endtask : t_mul

  task automatic t_div();
    r(32'hf0f6, 2, 0, 0, 29, OP_DIV);
    r(32'hf0f7, 2, 0, 0, 38, OP_DIV);
    r(32'h30f6, 2, 1, 0, 35, OP_DIV);
    r(32'h30f7, 2, 1, 0, 48, OP_DIV);
    r(32'hf8f6, 2, 0, 15, 52, OP_SIGNED_QUOTIENT_OP);
    r(32'h38f7, 2, 0, 3, 62, OP_SIGNED_QUOTIENT_OP);
    $display("test div finished");
  endtask : t_div

  task automatic t_adj();
    r(32'h0ad4, 2, 1, 0, 19, OP_AAM);
    r(32'h0ad5, 2, 1, 0, 15, OP_AAD);
    r(32'h98, 1, 0, 0, 2, OP_CBW);
    r(32'h99, 1, 0, 0, 4, OP_CWD);
    $display("test adjust finished");
  endtask : t_adj

  task automatic t_shift();
    r(32'he0d0, 2, 0, 0, 2, OP_SHIFT1);
    cmp_cyc(mdl_cyc_t'(uop.shift_op_select), 4);
    r(32'hc0d0, 2, 0, 0, 2, OP_SHIFT1);
    cmp_cyc(mdl_cyc_t'(uop.shift_op_select), 0);
    r(32'h20d1, 2, 1, 0, 15, OP_SHIFT1);
    count_register <= 8'h07;
    r(32'he0d2, 2, 0, 0, 12, OP_SHIFTCL);
    count_register <= 8'h00;
    r(32'h20d3, 2, 0, 0, 17, OP_SHIFTCL);
    r(32'h03c0c0, 3, 0, 0, 8, OP_SHIFTIMM);
    r(32'h0320c1, 3, 0, 0, 20, OP_SHIFTIMM);
    $display("test shift finished");
  endtask : t_shift

  task automatic t_logic();
    r(32'hc020, 2, 0, 0, 3, OP_AND);
    r(32'h0021, 2, 1, 0, 18, OP_AND);
    cmp_bit(uop.word, 1'b1);
    cmp_bit(uop.to_reg, 1'b0);
    r(32'h05e080, 3, 0, 0, 4, OP_AND);
    r(32'h341220_81, 4, 0, 0, 16, OP_AND);
    r(32'h0524, 2, 0, 0, 3, OP_AND);
    r(32'h341225, 3, 0, 0, 4, OP_AND);
    r(32'hc084, 2, 0, 0, 3, OP_TEST);
    r(32'h0085, 2, 1, 0, 14, OP_TEST);
    r(32'h05c0f6, 3, 0, 0, 4, OP_TEST);
    r(32'h341200f7, 4, 0, 0, 10, OP_TEST);
    r(32'h05a8, 2, 0, 0, 3, OP_TEST);
    r(32'h3412a9, 3, 0, 0, 4, OP_TEST);
    r(32'hc008, 2, 0, 0, 3, OP_OR);
    r(32'h000b, 2, 1, 0, 14, OP_OR);
    cmp_bit(uop.to_reg, 1'b1);
    r(32'h05c880, 3, 0, 0, 4, OP_OR);
    r(32'h34120881, 4, 0, 0, 16, OP_OR);
    r(32'h050c, 2, 0, 0, 3, OP_OR);
    r(32'h34120d, 3, 0, 0, 4, OP_OR);
    $display("test logic finished");
  endtask : t_logic

  task automatic t_bad();
    bad(32'h82, 1);
    bad(32'hc8f6, 2);
    bad(32'h0bd4, 2);
    $display("test refused finished");
  endtask : t_bad

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    cmp_bit(busy, 1'b0);
    cmp_cyc(cycles, 0);
    t_mul();
    t_div();
    t_adj();
    t_shift();
    t_logic();
    t_bad();
    print_verdict();
  end
endmodule : mdl_decoder_tb
`default_nettype wire
